// *** verilog/mpms_pkg.sv ***
// constants and state type for the module power-mode sequencer
package mpms_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ = 200000;
    localparam int unsigned TRIG_MIN_MS = 300;
    localparam int unsigned RESTART_MIN_MS = 200;
    localparam int unsigned OFF_MS = 8000;
    // least times: low must last longer than the figure, so one cycle more
    localparam int unsigned TRIG_CYC = TRIG_MIN_MS * CLK_KHZ + 1;
    localparam int unsigned RESTART_CYC = RESTART_MIN_MS * CLK_KHZ + 1;
    localparam int unsigned OFF_CYC = OFF_MS * CLK_KHZ + 1;
    localparam int unsigned CNT_W = 32;

    // ------------------------------------------------------------
    // reset values of the power outputs
    // ------------------------------------------------------------
    localparam logic RTC_EN_RST = 1'b1;
    localparam logic CORE_EN_RST = 1'b0;
    localparam logic CPU_RESET_RST = 1'b0;

    // ------------------------------------------------------------
    // sequencer states, gray along off-start-init-idle-sleep
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF      = 3'h0,
        ST_START    = 3'h1,
        ST_FW_INIT  = 3'h3,
        ST_IDLE     = 3'h2,
        ST_SLEEP    = 3'h6,
        ST_RESTART  = 3'h7
    } mpms_state_e;

endpackage : mpms_pkg

// *** verilog/mpms_low_timer.sv ***
// saturating timer for the continuous low time of an active-low line
`timescale 1ns/1ps
module mpms_low_timer #(
    parameter int unsigned CNT_W = 32,
    parameter int unsigned LIMIT = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic clear,
    input wire logic level_n,
    output logic hit
);
    logic [CNT_W-1:0] count;
    wire restart_count = !enable || clear || level_n;
    wire at_limit = (count == CNT_W'(LIMIT));

    always_ff @(posedge clk) begin
        if (rst || restart_count) begin
            count <= '0;
        end else if (!at_limit) begin
            count <= count + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst || restart_count) begin
            hit <= 1'b0;
        end else begin
            hit <= (count == CNT_W'(LIMIT - 1)) || at_limit;
        end
    end
endmodule : mpms_low_timer

// *** verilog/mpms_sequencer.sv ***
// power-mode and start-up sequencer of the radio module
//
// Overview of operation
// - power-on request accepted only while the main supply is present
// - power-on trigger is active low and level sensitive
// - trigger starts the device only from power down, ignored elsewhere
// - trigger held low keeps the device running, no release needed
// - sleep when power saving on, no call, usb suspended or absent, serial port idle
// - stay idle when power saving is off or usb active, no call
// - in power down only the rtc regulator stays on
// - in power down software is stopped, interfaces do not respond
// - out-of-limit voltage or temperature after start switches off at once
// - airplane mode disables radio, detaches network, rejects radio commands
// - functionality-level command after start-up causes a restart
// - emergency restart line low gives a hardware restart
// - emergency line not released after restart keeps restarting
// - emergency line low beyond 8000 ms switches off directly
// - start-up complete when clear-to-send, data-set-ready and ring are low
`timescale 1ns/1ps
module mpms_sequencer #(
    parameter int unsigned TRIG_CYC = mpms_pkg::TRIG_CYC,
    parameter int unsigned RESTART_CYC = mpms_pkg::RESTART_CYC,
    parameter int unsigned OFF_CYC = mpms_pkg::OFF_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic main_supply,
    input wire logic power_on_trigger_n,
    input wire logic emergency_restart_n,
    input wire logic call_active,
    input wire logic usb_present,
    input wire logic usb_suspended,
    input wire logic serial_active,
    input wire logic power_save_en,
    input wire logic limit_fault,
    input wire logic shutdown_cmd,
    input wire logic restart_cmd,
    input wire logic airplane_req,
    input wire logic radio_cmd,
    input wire logic primary_clear_to_send,
    input wire logic primary_data_set_ready,
    input wire logic primary_ring_indicator,
    output logic rtc_regulator_en,
    output logic core_power_en,
    output logic iface_enable,
    output logic cpu_reset,
    output logic fw_ready,
    output logic sleep_mode,
    output logic radio_en,
    output logic network_attached,
    output logic radio_cmd_reject,
    output logic [2:0] mode
);
    mpms_pkg::mpms_state_e state;
    mpms_pkg::mpms_state_e next_state;

    // ------------------------------------------------------------
    // line timers
    // ------------------------------------------------------------
    logic trig_hit;
    logic rst_hit;
    logic off_hit;
    wire powered = (state != mpms_pkg::ST_OFF);
    wire trig_en = !powered && main_supply;
    wire in_restart = (state == mpms_pkg::ST_RESTART);

    mpms_low_timer #(.CNT_W(mpms_pkg::CNT_W), .LIMIT(TRIG_CYC)) u_trig_timer (
        .clk(clk),
        .rst(rst),
        .enable(trig_en),
        .clear(1'b0),
        .level_n(power_on_trigger_n),
        .hit(trig_hit)
    );

    // re-armed in each restart so a held line restarts again
    mpms_low_timer #(.CNT_W(mpms_pkg::CNT_W), .LIMIT(RESTART_CYC)) u_restart_timer (
        .clk(clk),
        .rst(rst),
        .enable(powered),
        .clear(in_restart),
        .level_n(emergency_restart_n),
        .hit(rst_hit)
    );

    mpms_low_timer #(.CNT_W(mpms_pkg::CNT_W), .LIMIT(OFF_CYC)) u_off_timer (
        .clk(clk),
        .rst(rst),
        .enable(powered),
        .clear(1'b0),
        .level_n(emergency_restart_n),
        .hit(off_hit)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire stop = !main_supply || limit_fault || shutdown_cmd || off_hit;
    wire running = (state == mpms_pkg::ST_IDLE) || (state == mpms_pkg::ST_SLEEP);
    wire restart_go = rst_hit || (running && restart_cmd);
    wire fw_done = !primary_clear_to_send && !primary_data_set_ready
        && !primary_ring_indicator;
    wire usb_quiet = usb_suspended || !usb_present;
    wire sleep_cond = power_save_en && !call_active && usb_quiet && !serial_active;
    wire next_on = (next_state != mpms_pkg::ST_OFF);
    wire next_run = (next_state == mpms_pkg::ST_IDLE) || (next_state == mpms_pkg::ST_SLEEP);

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            mpms_pkg::ST_OFF: begin
                if (trig_en && trig_hit) begin
                    next_state = mpms_pkg::ST_START;
                end
            end
            mpms_pkg::ST_START: begin
                next_state = mpms_pkg::ST_FW_INIT;
            end
            mpms_pkg::ST_FW_INIT: begin
                if (rst_hit) begin
                    next_state = mpms_pkg::ST_RESTART;
                end else if (fw_done) begin
                    next_state = mpms_pkg::ST_IDLE;
                end
            end
            mpms_pkg::ST_IDLE, mpms_pkg::ST_SLEEP: begin
                if (restart_go) begin
                    next_state = mpms_pkg::ST_RESTART;
                end else if (sleep_cond) begin
                    next_state = mpms_pkg::ST_SLEEP;
                end else begin
                    next_state = mpms_pkg::ST_IDLE;
                end
            end
            mpms_pkg::ST_RESTART: begin
                next_state = mpms_pkg::ST_START;
            end
            default: begin
                next_state = mpms_pkg::ST_OFF;
            end
        endcase
        if (powered && stop) begin
            next_state = mpms_pkg::ST_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= mpms_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // registered outputs, aligned with the state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rtc_regulator_en <= mpms_pkg::RTC_EN_RST;
            core_power_en <= mpms_pkg::CORE_EN_RST;
            iface_enable <= 1'b0;
            cpu_reset <= mpms_pkg::CPU_RESET_RST;
            fw_ready <= 1'b0;
            sleep_mode <= 1'b0;
            radio_en <= 1'b0;
            network_attached <= 1'b0;
            radio_cmd_reject <= 1'b0;
            mode <= 3'h0;
        end else begin
            rtc_regulator_en <= 1'b1;
            core_power_en <= next_on;
            iface_enable <= next_run;
            cpu_reset <= (next_state == mpms_pkg::ST_START)
                || (next_state == mpms_pkg::ST_RESTART);
            fw_ready <= next_run;
            sleep_mode <= (next_state == mpms_pkg::ST_SLEEP);
            radio_en <= next_run && !airplane_req;
            network_attached <= next_run && !airplane_req;
            radio_cmd_reject <= running && airplane_req && radio_cmd;
            mode <= next_state;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_released;
        in_restart && !stop;
    endsequence
    sequence s_reboot;
        (state == mpms_pkg::ST_START) && cpu_reset ##1 (state == mpms_pkg::ST_FW_INIT);
    endsequence

    a_no_supply_off: assert property (!powered && !main_supply |=> !powered)
        else $error("started without main supply");
    a_trig_start: assert property (trig_en && trig_hit |=> state == mpms_pkg::ST_START)
        else $error("held trigger did not start device");
    a_short_trig: assert property ($rose(trig_en) ##1 1 |-> !trig_hit)
        else $error("trigger accepted too early");
    a_trig_ignored: assert property (powered |-> !trig_en)
        else $error("trigger counted while running");
    a_trig_held_run: assert property (running && !power_on_trigger_n && !stop && !restart_go
        |=> running)
        else $error("held trigger stopped device");
    a_sleep_entry: assert property (running && sleep_cond && !stop && !restart_go
        |=> sleep_mode && state == mpms_pkg::ST_SLEEP)
        else $error("sleep not entered");
    a_idle_hold: assert property (running && !sleep_cond && !stop && !restart_go
        |=> state == mpms_pkg::ST_IDLE && !sleep_mode)
        else $error("left idle wrongly");
    a_off_power: assert property (!powered |-> rtc_regulator_en && !core_power_en)
        else $error("power rails wrong in power down");
    a_off_iface: assert property (!powered |-> !iface_enable && !radio_en)
        else $error("interfaces live in power down");
    a_fault_off: assert property (powered && limit_fault |=> !powered && !core_power_en)
        else $error("limit fault did not switch off");
    a_airplane_radio: assert property (airplane_req |=> !radio_en && !network_attached)
        else $error("radio on in airplane mode");
    // a stop in the middle of a restart wins, so each step waits for no stop
    a_cmd_restart: assert property (running && restart_cmd && !stop ##1 !stop
        |-> in_restart ##1 (state == mpms_pkg::ST_START) && cpu_reset)
        else $error("restart command ignored");
    a_restart_seq: assert property (s_released ##1 !stop |-> s_reboot)
        else $error("restart did not reboot");
    a_held_restart: assert property (state == mpms_pkg::ST_FW_INIT && rst_hit && !stop
        |=> in_restart)
        else $error("held line did not restart again");
    a_emerg_off: assert property (powered && off_hit |=> !powered)
        else $error("long emergency low did not switch off");
    a_fw_done: assert property (state == mpms_pkg::ST_FW_INIT && fw_done && !rst_hit
        && !stop |=> fw_ready)
        else $error("start-up completion missed");
endmodule : mpms_sequencer

// *** bench/mpms_host_model.sv ***
// host-side model driving the power-on trigger and emergency restart lines
`timescale 1ns/1ps
module mpms_host_model (
    input wire logic clk,
    output logic power_on_trigger_n,
    output logic emergency_restart_n
);
    // ------------------------------------------------------------
    // line control
    // ------------------------------------------------------------
    // trigger tied to ground at power-up, emergency line pulled up
    initial begin
        power_on_trigger_n = 1'b0;
        emergency_restart_n = 1'b1;
    end

    task automatic trig_set(input logic lvl);
        @(posedge clk);
        power_on_trigger_n <= lvl;
    endtask : trig_set

    // low for exactly n sampled edges
    task automatic trig_pulse(input int n);
        trig_set(1'b0);
        repeat (n) @(posedge clk);
        power_on_trigger_n <= 1'b1;
    endtask : trig_pulse

    task automatic emerg_set(input logic lvl);
        @(posedge clk);
        emergency_restart_n <= lvl;
    endtask : emerg_set
endmodule : mpms_host_model

// *** bench/module_power_mode_sequencer_tb_top.sv ***
// self-checking bench for the module power-mode sequencer
`timescale 1ns/1ps
module module_power_mode_sequencer_tb_top;
    localparam int unsigned TRIG = 20;
    localparam int unsigned RST_C = 10;
    localparam int unsigned OFF_C = 60;
    typedef struct {bit kind; logic [10:0] exp;} mpms_note_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic supply = 1'b0, call = 1'b0, usb_pr = 1'b1, usb_sus = 1'b0, ser_act = 1'b0;
    logic psave = 1'b0, fault = 1'b0, shut = 1'b0, rcmd = 1'b0, air = 1'b0, radio_cmd = 1'b0;
    logic [2:0] ser_lines = 3'h7;
    logic [2:0] rej_cnt = 3'h0;
    logic look = 1'b0;
    int errors = 0;
    int checked = 0;
    int unsigned seed;
    mpms_note_s notes[$];
    mpms_note_s cur;
    logic [10:0] got;
    wire logic trig_n, emerg_n, rtc_en, core_en, if_en, cpu_rst, fw_rdy, slp, rad, net, rej;
    wire logic [2:0] mode;
    wire logic [10:0] obs = {mode, core_en, if_en, fw_rdy, slp, rad, net, rtc_en, cpu_rst};

    always #2.5 clk = ~clk;

    mpms_host_model i_mpms_host_model (.clk(clk), .power_on_trigger_n(trig_n),
        .emergency_restart_n(emerg_n));

    mpms_sequencer #(.TRIG_CYC(TRIG), .RESTART_CYC(RST_C), .OFF_CYC(OFF_C)) i_mpms_sequencer (
        .clk(clk), .rst(rst), .main_supply(supply), .power_on_trigger_n(trig_n),
        .emergency_restart_n(emerg_n), .call_active(call), .usb_present(usb_pr),
        .usb_suspended(usb_sus), .serial_active(ser_act), .power_save_en(psave),
        .limit_fault(fault), .shutdown_cmd(shut), .restart_cmd(rcmd), .airplane_req(air),
        .radio_cmd(radio_cmd), .primary_clear_to_send(ser_lines[2]),
        .primary_data_set_ready(ser_lines[1]), .primary_ring_indicator(ser_lines[0]),
        .rtc_regulator_en(rtc_en), .core_power_en(core_en), .iface_enable(if_en),
        .cpu_reset(cpu_rst), .fw_ready(fw_rdy), .sleep_mode(slp), .radio_en(rad),
        .network_attached(net), .radio_cmd_reject(rej), .mode(mode));

    // ------------------------------------------------------------
    // expectations and comparison
    // ------------------------------------------------------------
    function automatic logic [10:0] exp_vec(input mpms_pkg::mpms_state_e m, input logic a);
        logic on, run;
        on = (m != mpms_pkg::ST_OFF);
        run = (m == mpms_pkg::ST_IDLE) || (m == mpms_pkg::ST_SLEEP);
        exp_vec = {m, on, run, run, m == mpms_pkg::ST_SLEEP, run && !a, run && !a, 1'b1,
            (m == mpms_pkg::ST_START) || (m == mpms_pkg::ST_RESTART)};
    endfunction : exp_vec

    task automatic note(input bit k, input logic [10:0] e);
        notes.push_back('{k, e});
        look = 1'b1;
        #1 look = 1'b0;
    endtask : note

    task automatic wait_mode(input mpms_pkg::mpms_state_e m, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if (mode === m) break;
        end
        note(1'b0, exp_vec(m, air));
    endtask : wait_mode

    always @(posedge look) begin
        cur = notes.pop_front();
        got = cur.kind ? {8'h00, rej_cnt} : obs;
        checked++;
        if (got !== cur.exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", cur.kind ? "reject" : "outputs", cur.exp, got);
        end
    end

    task automatic results();
        if (errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    initial begin
        repeat (2000) @(posedge clk);
        errors++;
        results();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        seed = $urandom(89536);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (30) @(posedge clk);
        #1;
        note(1'b0, exp_vec(mpms_pkg::ST_OFF, 1'b0));
        i_mpms_host_model.trig_set(1'b1);
        supply <= 1'b1;
        i_mpms_host_model.trig_pulse(1 + $urandom % (TRIG - 2));
        repeat (4) @(posedge clk);
        #1;
        note(1'b0, exp_vec(mpms_pkg::ST_OFF, 1'b0));
        i_mpms_host_model.trig_set(1'b0);
        repeat (TRIG) @(posedge clk);
        #1;
        note(1'b0, exp_vec(mpms_pkg::ST_OFF, 1'b0));
        wait_mode(mpms_pkg::ST_START, 4);
        wait_mode(mpms_pkg::ST_FW_INIT, 4);
        repeat (3) @(posedge clk);
        #1;
        note(1'b0, exp_vec(mpms_pkg::ST_FW_INIT, 1'b0));
        @(posedge clk);
        ser_lines <= 3'h0;
        wait_mode(mpms_pkg::ST_IDLE, 4);
        @(posedge clk);
        psave <= 1'b1;
        usb_sus <= 1'b1;
        wait_mode(mpms_pkg::ST_SLEEP, 4);
        @(posedge clk);
        call <= 1'b1;
        wait_mode(mpms_pkg::ST_IDLE, 4);
        @(posedge clk);
        call <= 1'b0;
        wait_mode(mpms_pkg::ST_SLEEP, 4);
        @(posedge clk);
        usb_sus <= 1'b0;
        wait_mode(mpms_pkg::ST_IDLE, 4);
        @(posedge clk);
        air <= 1'b1;
        @(posedge clk);
        radio_cmd <= 1'b1;
        @(posedge clk);
        radio_cmd <= 1'b0;
        // reject is registered on this edge, count from here
        repeat (4) begin
            #1;
            rej_cnt = rej_cnt + {2'h0, rej};
            @(posedge clk);
        end
        note(1'b1, 11'h001);
        wait_mode(mpms_pkg::ST_IDLE, 1);
        @(posedge clk);
        air <= 1'b0;
        rcmd <= 1'b1;
        wait_mode(mpms_pkg::ST_RESTART, 3);
        @(posedge clk);
        rcmd <= 1'b0;
        wait_mode(mpms_pkg::ST_IDLE, 6);
        i_mpms_host_model.trig_set(1'b1);
        i_mpms_host_model.emerg_set(1'b0);
        // firmware lines high again so each restart waits in start-up
        ser_lines <= 3'h7;
        repeat (RST_C - 1) @(posedge clk);
        #1;
        note(1'b0, exp_vec(mpms_pkg::ST_IDLE, 1'b0));
        wait_mode(mpms_pkg::ST_RESTART, 6);
        wait_mode(mpms_pkg::ST_FW_INIT, 4);
        wait_mode(mpms_pkg::ST_RESTART, RST_C + 4);
        wait_mode(mpms_pkg::ST_OFF, OFF_C);
        i_mpms_host_model.emerg_set(1'b1);
        ser_lines <= 3'h0;
        i_mpms_host_model.trig_pulse(TRIG + 3);
        wait_mode(mpms_pkg::ST_IDLE, 12);
        @(posedge clk);
        fault <= 1'b1;
        wait_mode(mpms_pkg::ST_OFF, 2);
        results();
    end
endmodule : module_power_mode_sequencer_tb_top
